// >>> core/ir_readout_defs.vh
// Purpose: Shared offsets, fields, codes and timing counts of the IR read-out block.
// Assumes: 100 MHz pclk, APB with 32-bit data, one register per aligned word.
// Notes: All values used by the design live here as macros.
`ifndef IR_READOUT_DEFS_VH
`define IR_READOUT_DEFS_VH

// ==================================================================
// Register byte offsets
`define OFS_CTRL 8'h00
`define OFS_KEY 8'h04
`define OFS_ST1 8'h08
`define OFS_DATA_FIRST 8'h0c
`define OFS_DATA_LAST 8'h1c
`define OFS_ST2 8'h20
`define OFS_STATE 8'h24

// ==================================================================
// Control register fields
`define CTRL_MODE_LSB 0
`define CTRL_MODE_MSB 2
`define CTRL_MEM_BIT 3
`define CTRL_FC_LSB 4
`define CTRL_FC_MSB 6
`define CTRL_INT_EN_BIT 7
`define CTRL_SOFTWARE_RESET_BIT_BIT 8

// Status register fields
`define ST1_READY_BIT 0
`define ST1_OVERRUN_BIT 1
`define ST2_PROTECT_BIT 0

// ==================================================================
// Operating mode field codes
`define MODE_STANDBY 3'h0
`define MODE_MEMORY 3'h1
`define MODE_SINGLE 3'h2
`define MODE_CONT0 3'h4
`define MODE_CONT1 3'h5
`define MODE_CONT2 3'h6
`define MODE_CONT3 3'h7
`define UNLOCK_KEY 8'ha5

// Sequencer states
`define ST_STANDBY 3'h0
`define ST_MEASURE 3'h1
`define ST_WAIT 3'h2
`define ST_HELD 3'h3
`define ST_MEMORY 3'h4
`define ST_SWITCH 3'h5

// ==================================================================
// Timing
`define CLK_PERIOD_NS 10
`define MEAS_BASE_NS 10000
`define MEAS_BASE_CYC ((`MEAS_BASE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CNT_W 21

`endif

// >>> core/sync2.v
// Purpose: Two flip-flop synchroniser for one asynchronous level.
// Assumes: Input is a pin from outside the pclk domain.
// Notes: Reset value is a parameter so a pin can idle high.
module sync2 #(
    parameter RESET_VAL = 1'b0
) (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // Level in and out
    input wire d,
    output reg q
);

reg meta_r;

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        meta_r <= RESET_VAL;
        q <= RESET_VAL;
    end else begin
        meta_r <= d;
        q <= meta_r;
    end
end

endmodule // sync2

// >>> core/ir_readout.v
// What this block does
// - After power-up with power-down pin high, sit in stand-by until mode written.
// - Power-down pin low stops every function, bus answers included.
// - Stand-by keeps registers until software reset; memory is closed there.
// - Memory access only with mode 001 and memory bit set; no measuring.
// - Memory writes allowed only after key A5 written in memory-access mode.
// - Mode 010 measures once, stores results, then powers analog off.
// - Single shot returns to stand-by after the span ST1 to ST2 is read.
// - Mode 100 measures back to back, period from filter cut-off field.
// - Modes 101 to 111 alternate a measurement and a mode-dependent wait.
// - Continuous modes end only when mode 000 is written; here a write of any other mode also ends them.
// - Rewriting the mode mid-measurement aborts it and keeps old results.
// - Storing results sets data-ready; enabled interrupt output goes high.
// - Overrun shows a result was left unread before the current read.
// - First read of data or second status starts read-out, clears both flags.
// - Data registers frozen from read-out start until second status read.
// - Reads during a measurement return the previous stored results.
// - Unread result overwritten by newer one keeps data-ready and sets overrun.
// - Result ending during read-out is discarded and sets overrun.
// - Switch operation has only power-down and auto-repeating measurement.
// - Both address-select pins high select switch operation, bus disabled.
// - Measure to wait ratio is 1:1, 1:3 and 1:7 in modes 1 to 3.
//
// Purpose: Mode sequencer and measurement read-out handshake behind an APB slave.
// Assumes: Analog results arrive on pclk; pins are synchronised here.
// Notes: APB answers with no wait state; pslverr marks unmapped or disabled access.
//
// Decided for this implementation: the APB register port and the address map.
`include "ir_readout_defs.vh"

module ir_readout #(
    parameter MEAS_BASE = `MEAS_BASE_CYC
) (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    // Device pins
    input wire power_down_pin,
    input wire address_select_pin_0,
    input wire address_select_pin_1,
    output wire int_out,
    // Analog front end results
    input wire [15:0] adc_ir1,
    input wire [15:0] adc_ir2,
    input wire [15:0] adc_ir3,
    input wire [15:0] adc_ir4,
    input wire [15:0] adc_temp,
    output wire analog_on,
    // Switch operation conditions from non-volatile memory
    input wire [2:0] sw_filter_cutoff,
    // Non-volatile memory gates
    output wire nvm_access,
    output wire nvm_write_en
);

// ==================================================================
// Pin synchronisers
wire pdn_s;
wire address_select_pin_0_s;
wire address_select_pin_1_s;

sync2 #(.RESET_VAL(1'b0)) u_sync_pdn (
    .pclk(pclk),
    .presetn(presetn),
    .d(power_down_pin),
    .q(pdn_s)
);

sync2 #(.RESET_VAL(1'b0)) u_sync_address_select_pin_0 (
    .pclk(pclk),
    .presetn(presetn),
    .d(address_select_pin_0),
    .q(address_select_pin_0_s)
);

sync2 #(.RESET_VAL(1'b0)) u_sync_address_select_pin_1 (
    .pclk(pclk),
    .presetn(presetn),
    .d(address_select_pin_1),
    .q(address_select_pin_1_s)
);

// ==================================================================
// State
reg [2:0] operating_mode_field_r;
reg memory_mode_bit_r;
reg [2:0] filter_cutoff_field_r;
reg int_en_r;
reg [7:0] memory_unlock_key_r;
reg [2:0] state_r;
reg [`CNT_W-1:0] cnt_r;
reg data_ready_flag_r;
reg overrun_flag_r;
reg reading_r;
reg sw_mode_r;
reg started_r;
reg [15:0] data_r [0:4];

// ==================================================================
// Bus decode
wire bus_on = pdn_s && started_r && !sw_mode_r;
wire acc = psel && penable;
wire wr = acc && pwrite && bus_on;
wire rd = acc && !pwrite && bus_on;
wire wr_ctrl = wr && (paddr == `OFS_CTRL);
wire wr_key = wr && (paddr == `OFS_KEY);
wire rd_st2 = rd && (paddr == `OFS_ST2);
wire rd_data = rd && (paddr >= `OFS_DATA_FIRST) && (paddr <= `OFS_DATA_LAST)
    && (paddr[1:0] == 2'b00);
wire soft_rst = wr_ctrl && pwdata[`CTRL_SOFTWARE_RESET_BIT_BIT];
wire [2:0] new_mode = pwdata[`CTRL_MODE_MSB:`CTRL_MODE_LSB];
wire mode_written = wr_ctrl && !soft_rst;
wire mapped = (paddr == `OFS_CTRL) || (paddr == `OFS_KEY) || (paddr == `OFS_ST1)
    || (paddr == `OFS_ST2) || (paddr == `OFS_STATE) || (paddr[1:0] == 2'b00
    && paddr >= `OFS_DATA_FIRST && paddr <= `OFS_DATA_LAST);

assign pready = 1'b1;
assign pslverr = acc && (!bus_on || !mapped);

wire rd_start = (rd_data || rd_st2) && !reading_r;

// ==================================================================
// Measurement timing
wire [2:0] fc_sel = sw_mode_r ? sw_filter_cutoff : filter_cutoff_field_r;
wire [`CNT_W-1:0] meas_full = MEAS_BASE[`CNT_W-1:0] << fc_sel;
wire [`CNT_W-1:0] meas_len = meas_full - 1'b1;
reg [`CNT_W-1:0] wait_len;

always @* begin
    case (operating_mode_field_r)
        `MODE_CONT1: wait_len = meas_len;
        `MODE_CONT2: wait_len = (meas_full << 1) + meas_full - 1'b1;
        `MODE_CONT3: wait_len = (meas_full << 3) - meas_full - 1'b1;
        default: wait_len = meas_len;
    endcase
end

wire measuring = (state_r == `ST_MEASURE) || (state_r == `ST_SWITCH);
wire done_evt = measuring && (cnt_r == {`CNT_W{1'b0}}) && !mode_written;
wire discard = reading_r || rd_start;

assign analog_on = measuring;
assign nvm_access = (state_r == `ST_MEMORY);
assign nvm_write_en = nvm_access && (memory_unlock_key_r == `UNLOCK_KEY);
assign int_out = int_en_r && data_ready_flag_r && !sw_mode_r;

// ==================================================================
// Sequencer, flags and registers
integer i;

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        operating_mode_field_r <= 3'h0;
        memory_mode_bit_r <= 1'b0;
        filter_cutoff_field_r <= 3'h0;
        int_en_r <= 1'b0;
        memory_unlock_key_r <= 8'h00;
        state_r <= `ST_STANDBY;
        cnt_r <= {`CNT_W{1'b0}};
        data_ready_flag_r <= 1'b0;
        overrun_flag_r <= 1'b0;
        reading_r <= 1'b0;
        sw_mode_r <= 1'b0;
        started_r <= 1'b0;
        for (i = 0; i < 5; i = i + 1) begin
            data_r[i] <= 16'h0000;
        end
    end else if (!pdn_s || soft_rst) begin
        operating_mode_field_r <= 3'h0;
        memory_mode_bit_r <= 1'b0;
        filter_cutoff_field_r <= 3'h0;
        int_en_r <= 1'b0;
        memory_unlock_key_r <= 8'h00;
        state_r <= `ST_STANDBY;
        cnt_r <= {`CNT_W{1'b0}};
        data_ready_flag_r <= 1'b0;
        overrun_flag_r <= 1'b0;
        reading_r <= 1'b0;
        for (i = 0; i < 5; i = i + 1) begin
            data_r[i] <= 16'h0000;
        end
        // Straps are re-sampled at every power-down release.
        if (!pdn_s) begin
            started_r <= 1'b0;
        end
    end else if (!started_r) begin
        started_r <= 1'b1;
        sw_mode_r <= address_select_pin_0_s && address_select_pin_1_s;
        state_r <= (address_select_pin_0_s && address_select_pin_1_s) ? `ST_SWITCH : `ST_STANDBY;
        cnt_r <= meas_len;
    end else begin
        // Sequencer.
        case (state_r)
            `ST_MEASURE: begin
                if (cnt_r != {`CNT_W{1'b0}}) begin
                    cnt_r <= cnt_r - 1'b1;
                end else if (operating_mode_field_r == `MODE_SINGLE) begin
                    state_r <= `ST_HELD;
                end else if (operating_mode_field_r == `MODE_CONT0) begin
                    cnt_r <= meas_len;
                end else begin
                    state_r <= `ST_WAIT;
                    cnt_r <= wait_len;
                end
            end
            `ST_WAIT: begin
                if (cnt_r != {`CNT_W{1'b0}}) begin
                    cnt_r <= cnt_r - 1'b1;
                end else begin
                    state_r <= `ST_MEASURE;
                    cnt_r <= meas_len;
                end
            end
            `ST_SWITCH: begin
                if (cnt_r != {`CNT_W{1'b0}}) begin
                    cnt_r <= cnt_r - 1'b1;
                end else begin
                    cnt_r <= meas_len;
                end
            end
            `ST_STANDBY: begin
                cnt_r <= {`CNT_W{1'b0}};
            end
            `ST_HELD: begin
                cnt_r <= {`CNT_W{1'b0}};
            end
            `ST_MEMORY: begin
                cnt_r <= {`CNT_W{1'b0}};
            end
            default: begin
                state_r <= `ST_STANDBY;
            end
        endcase

        // Register writes. Mode changes assume the host went through stand-by.
        // host via stand-by
        if (wr_ctrl) begin
            operating_mode_field_r <= new_mode;
            memory_mode_bit_r <= pwdata[`CTRL_MEM_BIT];
            filter_cutoff_field_r <= pwdata[`CTRL_FC_MSB:`CTRL_FC_LSB];
            int_en_r <= pwdata[`CTRL_INT_EN_BIT];
            case (new_mode)
                `MODE_STANDBY: state_r <= `ST_STANDBY;
                `MODE_MEMORY: state_r <= pwdata[`CTRL_MEM_BIT] ? `ST_MEMORY : `ST_STANDBY;
                `MODE_SINGLE: state_r <= `ST_MEASURE;
                `MODE_CONT0: state_r <= `ST_MEASURE;
                `MODE_CONT1: state_r <= `ST_MEASURE;
                `MODE_CONT2: state_r <= `ST_MEASURE;
                `MODE_CONT3: state_r <= `ST_MEASURE;
                default: state_r <= `ST_STANDBY;
            endcase
            cnt_r <= (MEAS_BASE[`CNT_W-1:0] << pwdata[`CTRL_FC_MSB:`CTRL_FC_LSB]) - 1'b1;
            if (new_mode != `MODE_MEMORY) begin
                memory_unlock_key_r <= 8'h00;
            end
        end
        if (wr_key && state_r == `ST_MEMORY) begin
            memory_unlock_key_r <= pwdata[7:0];
        end

        // Read-out handshake; the set below wins over these clears.
        // clear on start
        if (rd_start) begin
            data_ready_flag_r <= 1'b0;
            overrun_flag_r <= 1'b0;
            reading_r <= 1'b1;
        end
        if (rd_st2) begin
            reading_r <= 1'b0;
            if (state_r == `ST_HELD && !wr_ctrl) begin
                operating_mode_field_r <= `MODE_STANDBY;
                state_r <= `ST_STANDBY;
            end
        end

        // Result store.
        if (done_evt) begin
            if (discard) begin
                overrun_flag_r <= 1'b1;
            end else begin
                data_r[0] <= adc_ir1;
                data_r[1] <= adc_ir2;
                data_r[2] <= adc_ir3;
                data_r[3] <= adc_ir4;
                data_r[4] <= adc_temp;
                data_ready_flag_r <= 1'b1;
                if (data_ready_flag_r) begin
                    overrun_flag_r <= 1'b1;
                end
            end
        end
    end
end

// ==================================================================
// Read data, captured in the setup phase so it is a flip-flop output
wire [2:0] data_idx = paddr[4:2] - 3'h3;

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite && bus_on) begin
        case (paddr)
            `OFS_CTRL: prdata <= {24'h000000, int_en_r, filter_cutoff_field_r,
                memory_mode_bit_r, operating_mode_field_r};
            `OFS_KEY: prdata <= {23'h000000, nvm_write_en, memory_unlock_key_r};
            `OFS_ST1: prdata <= {30'h00000000, overrun_flag_r, data_ready_flag_r};
            `OFS_ST2: prdata <= {31'h00000000, reading_r};
            `OFS_STATE: prdata <= {26'h0000000, sw_mode_r, nvm_write_en, nvm_access,
                state_r};
            default: begin
                if (mapped) begin
                    prdata <= {16'h0000, data_r[data_idx]};
                end else begin
                    prdata <= 32'h0000_0000;
                end
            end
        endcase
    end else if (!psel) begin
        prdata <= 32'h0000_0000;
    end
end

endmodule // ir_readout

// >>> testbench/ir_readout_chk.sv
// Purpose: Port-level checks of the IR read-out block.
// Assumes: A write counts at the edge where psel and penable are both high.
// Notes: Soft-reset writes are kept out of the control-write helper.
module ir_readout_chk #(
    parameter int MEAS_BASE = 1000
) (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // APB
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pslverr,
    // Pins and gates
    input wire power_down_pin,
    input wire int_out,
    input wire analog_on,
    input wire nvm_access,
    input wire nvm_write_en
);
    localparam int MAXM = MEAS_BASE + 2;
    wire acc = psel && penable;
    wire good = acc && !pslverr;
    wire cw = good && pwrite && paddr == 8'h00 && !pwdata[8];
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // ==================================================================
    // Bus and power
    a_unmapped_err: assert property (acc && paddr > 8'h24 |-> pslverr)
        else $error("unmapped access without error");
    a_err_quiet: assert property (acc && pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read returned data");
    a_pdn_bus_off: assert property (!power_down_pin [*4] ##0 acc |-> pslverr)
        else $error("bus answered in power-down");
    a_pdn_quiet: assert property (!power_down_pin [*4] |-> !analog_on && !int_out && !nvm_access)
        else $error("activity in power-down");
    // ==================================================================
    // Modes
    a_mem_enter: assert property (cw && pwdata[3:0] == 4'h9 |=> nvm_access && !analog_on)
        else $error("memory mode not entered");
    a_key_unlock: assert property (good && pwrite && paddr == 8'h04 && pwdata[7:0] == 8'ha5
        && nvm_access |=> nvm_write_en)
        else $error("unlock key ignored");
    a_write_gate: assert property (nvm_write_en |-> nvm_access)
        else $error("memory write open outside memory mode");
    a_single_once: assert property (cw && pwdata[6:0] == 7'h02
        |=> analog_on ##[1:MAXM] !analog_on [*4])
        else $error("single shot did not end");
    a_cont_start: assert property (cw && pwdata[2] |=> analog_on)
        else $error("continuous mode did not measure");
    a_stop_standby: assert property (cw && pwdata[3:0] == 4'h0
        |=> !analog_on && !nvm_access && !nvm_write_en)
        else $error("stand-by write left activity");
    a_int_cause: assert property ($rose(int_out) |-> $past(analog_on) || $past(cw))
        else $error("interrupt without stored result");
    a_int_off: assert property (cw && !pwdata[7] |=> !int_out)
        else $error("interrupt high while disabled");
endmodule // ir_readout_chk

bind ir_readout ir_readout_chk #(.MEAS_BASE(MEAS_BASE)) chk (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pslverr, .power_down_pin, .int_out, .analog_on,
    .nvm_access, .nvm_write_en);

// >>> testbench/apb_host.sv
// Purpose: APB controller model on the far side of the block.
// Assumes: Each transfer is entered just after a rising pclk edge.
// Notes: Fields hold until pready is sampled high; one idle cycle follows.
module apb_host (
    // Clock
    input wire pclk,
    // Request
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    // Answer
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                        output logic [31:0] r, output logic er, output logic hung);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 64) begin
            @(posedge pclk);
            n++;
        end
        hung = n >= 64;
        r = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
endmodule // apb_host

// >>> testbench/tb.sv
// Purpose: Self-checking bench for the IR read-out block.
// Assumes: Measurement base cut to 4 cycles, so a measure lasts 4 << fc cycles.
// Notes: Front-end codes count measuring cycles, which makes stored data predictable.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [7:0] a;
        logic w;
        logic [31:0] d;
        logic [31:0] q;
        logic e;
    } row_t;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic power_down_pin = 1'b1;
    logic address_select_pin_0 = 1'b0;
    logic address_select_pin_1 = 1'b0;
    logic [2:0] sw_filter_cutoff = 3'h0;
    logic [11:0] smp = 12'h0;
    wire [15:0] adc_ir1, adc_ir2, adc_ir3, adc_ir4, adc_temp;
    wire psel, penable, pwrite, pready, pslverr, int_out, analog_on, nvm_access, nvm_write_en;
    wire [7:0] paddr;
    wire [31:0] pwdata, prdata;
    int miscompares = 0;
    int cmp_count = 0;
    int p;
    logic [31:0] q, v;
    logic e;
    row_t rows [21];
    initial begin
        forever #5 pclk = ~pclk;
    end
    ir_readout #(.MEAS_BASE(4)) DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .power_down_pin, .address_select_pin_0, .address_select_pin_1,
        .int_out, .adc_ir1, .adc_ir2, .adc_ir3, .adc_ir4, .adc_temp, .analog_on,
        .sw_filter_cutoff, .nvm_access, .nvm_write_en);
    apb_host host (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
    // Counting every measuring cycle keeps back-to-back results distinct.
    always @(posedge pclk) begin
        if (analog_on) begin
            smp <= smp + 12'h1;
        end
    end
    // A powered-off front end shows the inverse code, so a late sample cannot pass by luck.
    assign adc_ir1 = analog_on ? {4'h1, smp} : ~{4'h1, smp};
    assign adc_ir2 = analog_on ? {4'h2, smp} : ~{4'h2, smp};
    assign adc_ir3 = analog_on ? {4'h3, smp} : ~{4'h3, smp};
    assign adc_ir4 = analog_on ? {4'h4, smp} : ~{4'h4, smp};
    assign adc_temp = analog_on ? {4'h5, smp} : ~{4'h5, smp};
    // ==================================================================
    // Tasks
    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
        cmp_count++;
        if (g !== x) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", n, x, g);
        end
    endtask
    task automatic acc(input logic [7:0] a, input logic w, input logic [31:0] d,
                       output logic [31:0] r, output logic er);
        logic h;
        host.xfer(a, w, d, r, er, h);
        chk("bus hang", 32'h0, {31'h0, h});
    endtask
    task automatic rdchk(input string n, input logic [7:0] a, input logic [31:0] x);
        logic [31:0] r;
        logic er;
        acc(a, 1'b0, 32'h0, r, er);
        chk(n, x, r);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic er;
        acc(a, 1'b1, d, r, er);
    endtask
    task automatic wait_lvl(input logic want_int);
        int n;
        n = 0;
        while ((want_int ? int_out : analog_on) !== 1'b1 && n < 200) begin
            @(posedge pclk);
            n++;
        end
    endtask
    task automatic period(output int c);
        wait_lvl(1'b0);
        c = 0;
        while (analog_on === 1'b1 && c < 100) begin
            @(posedge pclk);
            c++;
        end
        while (analog_on !== 1'b1 && c < 100) begin
            @(posedge pclk);
            c++;
        end
    endtask
    task automatic pdn_cycle();
        power_down_pin <= 1'b0;
        repeat (6) @(posedge pclk);
        power_down_pin <= 1'b1;
        repeat (6) @(posedge pclk);
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        #100us;
        miscompares++;
        tally_and_finish();
    end
    // ==================================================================
    // Sequence
    initial begin
        rows = '{'{8'h00, 1'b0, 32'h0, 32'h0, 1'b0}, '{8'h24, 1'b0, 32'h0, 32'h0, 1'b0},
            '{8'h00, 1'b1, 32'h50, 32'h0, 1'b0}, '{8'h00, 1'b0, 32'h0, 32'h50, 1'b0},
            '{8'h00, 1'b1, 32'h100, 32'h0, 1'b0}, '{8'h00, 1'b0, 32'h0, 32'h0, 1'b0},
            '{8'h00, 1'b1, 32'h01, 32'h0, 1'b0}, '{8'h24, 1'b0, 32'h0, 32'h0, 1'b0},
            '{8'h00, 1'b1, 32'h03, 32'h0, 1'b0}, '{8'h24, 1'b0, 32'h0, 32'h0, 1'b0},
            '{8'h00, 1'b1, 32'h09, 32'h0, 1'b0}, '{8'h24, 1'b0, 32'h0, 32'h0c, 1'b0},
            '{8'h04, 1'b1, 32'ha5, 32'h0, 1'b0}, '{8'h24, 1'b0, 32'h0, 32'h1c, 1'b0},
            '{8'h04, 1'b0, 32'h0, 32'h1a5, 1'b0}, '{8'h00, 1'b1, 32'h0, 32'h0, 1'b0},
            '{8'h04, 1'b0, 32'h0, 32'h0, 1'b0}, '{8'h04, 1'b1, 32'ha5, 32'h0, 1'b0},
            '{8'h04, 1'b0, 32'h0, 32'h0, 1'b0}, '{8'h28, 1'b0, 32'h0, 32'h0, 1'b1},
            '{8'hfc, 1'b1, 32'h1, 32'h0, 1'b1}};
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (6) @(posedge pclk);
        foreach (rows[i]) begin
            acc(rows[i].a, rows[i].w, rows[i].d, q, e);
            chk("error", {31'h0, rows[i].e}, {31'h0, e});
            if (!rows[i].w) begin
                chk("read", rows[i].q, q);
            end
        end
        $display("done table");
        wr(8'h00, 32'h82);
        wait_lvl(1'b1);
        @(posedge pclk);
        chk("int", 32'h1, {31'h0, int_out});
        chk("analog", 32'h0, {31'h0, analog_on});
        rdchk("st1", 8'h08, 32'h1);
        for (int i = 0; i < 5; i++) begin
            rdchk("data", 8'h0c + 8'(4 * i), {16'h0, 4'(i + 1), smp - 12'h1});
        end
        rdchk("st1 clr", 8'h08, 32'h0);
        chk("int clr", 32'h0, {31'h0, int_out});
        rdchk("st2", 8'h20, 32'h1);
        rdchk("mode", 8'h00, 32'h80);
        $display("done single");
        wr(8'h00, 32'h44);
        repeat (150) @(posedge pclk);
        rdchk("st1 over", 8'h08, 32'h3);
        rdchk("st1 none", 8'h08, 32'h3);
        acc(8'h0c, 1'b0, 32'h0, v, e);
        rdchk("st1 start", 8'h08, 32'h0);
        repeat (140) @(posedge pclk);
        rdchk("st1 skip", 8'h08, 32'h2);
        rdchk("held", 8'h0c, v);
        rdchk("st2 end", 8'h20, 32'h1);
        repeat (70) @(posedge pclk);
        acc(8'h0c, 1'b0, 32'h0, q, e);
        chk("moved", 32'h1, {31'h0, q !== v});
        acc(8'h20, 1'b0, 32'h0, q, e);
        wr(8'h00, 32'h0);
        $display("done continuous");
        for (int m = 5; m < 8; m++) begin
            wr(8'h00, {29'h0, 3'(m)});
            period(p);
            chk("period", 32'(4 << (m - 4)), 32'(p));
            wr(8'h00, 32'h0);
        end
        $display("done intermittent");
        wr(8'h00, 32'h80);
        power_down_pin <= 1'b0;
        repeat (6) @(posedge pclk);
        acc(8'h00, 1'b0, 32'h0, q, e);
        chk("pdn err", 32'h1, {31'h0, e});
        power_down_pin <= 1'b1;
        repeat (6) @(posedge pclk);
        rdchk("pdn ctrl", 8'h00, 32'h0);
        $display("done power");
        address_select_pin_0 <= 1'b1;
        address_select_pin_1 <= 1'b1;
        sw_filter_cutoff <= 3'h1;
        pdn_cycle();
        acc(8'h00, 1'b0, 32'h0, q, e);
        chk("sw err", 32'h1, {31'h0, e});
        wait_lvl(1'b0);
        chk("sw meas", 32'h1, {31'h0, analog_on});
        address_select_pin_1 <= 1'b0;
        pdn_cycle();
        acc(8'h00, 1'b0, 32'h0, q, e);
        chk("normal err", 32'h0, {31'h0, e});
        $display("done switch");
        tally_and_finish();
    end
endmodule // tb
